// File: rms_pkg.sv
// Purpose: shared constants for the resistive measurement sequencer
// Assumes: 250 MHz clock, APB register access with 32-bit data
// Notes: register offsets are byte addresses of aligned words
package rms_pkg;
    // register byte offsets
    localparam logic [7:0] RMS_CTRL_OFS = 8'h00;
    localparam logic [7:0] RMS_CFG_OFS = 8'h04;
    localparam logic [7:0] RMS_THR_OFS = 8'h08;
    localparam logic [7:0] RMS_RES_OFS = 8'h0c;
    localparam logic [7:0] RMS_STAT_OFS = 8'h10;
    localparam logic [7:0] RMS_ADC_OFS = 8'h14;
    // control fields
    localparam int RMS_START_BIT = 0;
    localparam int RMS_ACC_BIT = 1;
    localparam int RMS_PU_POS = 8;
    localparam int RMS_PD_POS = 16;
    // configuration fields
    localparam int RMS_AVG_POS = 0;
    localparam int RMS_RETRY_POS = 4;
    localparam int RMS_GND_POS = 8;
    localparam int RMS_NOISE_POS = 16;
    // threshold fields
    localparam int RMS_SBCORR_POS = 0;
    localparam int RMS_GNCORR_POS = 8;
    // result fields
    localparam int RMS_AVG_RPOS = 0;
    localparam int RMS_MIN_RPOS = 8;
    localparam int RMS_MAX_RPOS = 16;
    localparam int RMS_IDX_RPOS = 24;
    localparam int RMS_KIND_RPOS = 28;
    // reset values
    localparam logic [31:0] RMS_CFG_RST = 32'h0000_0480;
    localparam logic [31:0] RMS_THR_RST = 32'h0000_0000;
    localparam logic [31:0] RMS_CTRL_RST = 32'h0000_0000;
    // pin count: cc1, cc2, sideband1, sideband2, vbus, dp, dn
    localparam int RMS_NPINS = 7;
    localparam logic [6:0] RMS_SB_MASK = 7'h0c;
    localparam logic [7:0] RMS_STEP_BASE = 8'h3f;
    localparam logic [7:0] RMS_FULL = 8'hff;
    localparam logic [7:0] RMS_ZERO = 8'h00;
    // current indices in rising order
    localparam logic [1:0] RMS_I2UA = 2'b00;
    localparam logic [1:0] RMS_I128UA = 2'b11;
    // settle time of the analog network after a switch change
    localparam int RMS_SETTLE_NS = 40;
    localparam int RMS_CLK_MHZ = 250;
    localparam int RMS_SETTLE_CYC = (RMS_SETTLE_NS * RMS_CLK_MHZ + 999) / 1000;
    // result classes
    typedef enum logic [1:0] {
        RMS_OPEN = 2'b00,
        RMS_GROUND = 2'b01,
        RMS_ABORT = 2'b10,
        RMS_FINITE = 2'b11
    } rms_kind_t;
endpackage : rms_pkg

// File: rms_sample_acc.sv
// Purpose: accumulates a burst of ADC samples into mean, lowest and highest
// Assumes: one sample per adcValid pulse; clear before each burst
// Notes: mean is sum shifted by the exponent, truncated
`timescale 1ns/1ps
module rms_sample_acc
    import rms_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic adcValid,
    input wire logic [W-1:0] adcData,
    input wire logic [2:0] sampleCountExponent,
    output logic [W-1:0] meanValue,
    output logic [W-1:0] lowestValue,
    output logic [W-1:0] highestValue,
    output logic burstDone
);
    logic [W+7:0] sum_r, sum_nxt;
    logic [W-1:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic [8:0] target;

    // next accumulation state
    always_comb begin
        target = 9'(1) << sampleCountExponent;
        sum_nxt = sum_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (clear) begin
            sum_nxt = '0;
            lo_nxt = '1;
            hi_nxt = '0;
            cnt_nxt = '0;
        end else if (adcValid && {1'b0, cnt_r} < target) begin
            sum_nxt = sum_r + (W+8)'(adcData);
            if (adcData < lo_r) lo_nxt = adcData; // keep lowest [R4]
            if (adcData > hi_r) hi_nxt = adcData; // keep highest [R4]
            cnt_nxt = cnt_r + 8'd1;
            done_nxt = ({1'b0, cnt_r} + 9'd1 == target); // 2^n samples [R4]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sum_r <= '0;
            lo_r <= '1;
            hi_r <= '0;
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            sum_r <= sum_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign meanValue = W'(sum_r >> sampleCountExponent); // average [R4]
    assign lowestValue = lo_r;
    assign highestValue = hi_r;
    assign burstDone = done_r;
endmodule : rms_sample_acc

// File: rms_apb_regs.sv
// Purpose: APB slave holding control, configuration and threshold registers
// Assumes: zero wait states; unmapped addresses read zero and flag pslverr
// Notes: start bit self-clears when the sequencer reports completion
`timescale 1ns/1ps
module rms_apb_regs
    import rms_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] resultWord,
    input wire logic [31:0] statusWord,
    input wire logic seqDone,
    output logic [31:0] ctrlReg,
    output logic [31:0] cfgReg,
    output logic [31:0] thrReg
);
    logic [31:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt, thr_r, thr_nxt;
    logic acc, hit;

    // register write decode
    always_comb begin
        acc = psel && penable;
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        thr_nxt = thr_r;
        if (seqDone) ctrl_nxt[RMS_START_BIT] = 1'b0;
        if (acc && pwrite) begin
            case (paddr)
                RMS_CTRL_OFS: ctrl_nxt = pwdata;
                RMS_CFG_OFS: cfg_nxt = pwdata;
                RMS_THR_OFS: thr_nxt = pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= RMS_CTRL_RST;
            cfg_r <= RMS_CFG_RST;
            thr_r <= RMS_THR_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            thr_r <= thr_nxt;
        end
    end

    // read mux
    always_comb begin
        hit = 1'b1;
        case (paddr)
            RMS_CTRL_OFS: prdata = ctrl_r;
            RMS_CFG_OFS: prdata = cfg_r;
            RMS_THR_OFS: prdata = thr_r;
            RMS_RES_OFS: prdata = resultWord;
            RMS_STAT_OFS: prdata = statusWord;
            default: begin
                prdata = '0;
                hit = 1'b0;
            end
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign ctrlReg = ctrl_r;
    assign cfgReg = cfg_r;
    assign thrReg = thr_r;
endmodule : rms_apb_regs

// File: rms_sequencer.sv
// Purpose: sequences one resistive measurement, two in accessory mode, with current stepping and retry
// Assumes: ADC conversions requested by adcStart, answered by adcValid
// Notes: results land in the result register, classified into four kinds
`timescale 1ns/1ps
// Functional notes
// R1: one 8-bit ADC, four currents, pullup and pulldown switch banks shared
// R2: each pin has pulldown plus forced and sensed pullup switches
// R3: accessory mode pulls up only sideband pins, one at a time
// R4: take 2^exponent samples, keep max, min and average
// R5: start at 2uA, step by four while average low, stop at 128uA
// R6: step threshold is 0x3F minus active shift factor
// R7: sideband shift factor when only sideband pins pulled up, else general
// R8: sideband set always in accessory mode, else only sideband-only pullups
// R9: report average, minimum, maximum and 2-bit current index
// R10: open reports index 00 and all values 0xFF
// R11: ground at 128uA and average at or below threshold reports 11, zeros
// R12: retry when max saturates per the two conditions, up to retry limit
// R13: persisting retry reports abort with index 00 and zeros
// R14: finite when average above step threshold unsaturated, or above ground
// R15: software derates thresholds by current accuracy and resistor tolerance
// R16: index 00 2uA, 01 8uA, 10 32uA, 11 128uA
module rms_sequencer
    import rms_pkg::*;
#(
    parameter int NPINS = RMS_NPINS,
    parameter int SETTLE = RMS_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic adcStart,
    input wire logic adcValid,
    input wire logic [7:0] adcData,
    output logic [1:0] currentSelect,
    output logic currentEnable,
    output logic [NPINS-1:0] forcedPullup,
    output logic [NPINS-1:0] sensedPullup,
    output logic [NPINS-1:0] pinPulldown,
    output logic busy
);
    typedef enum logic [2:0] {
        RMS_IDLE = 3'b000,
        RMS_SETTLE = 3'b001,
        RMS_SAMPLE = 3'b011,
        RMS_JUDGE = 3'b010,
        RMS_DONE = 3'b110
    } rms_state_t;

    rms_state_t st_r, st_nxt;
    logic [31:0] ctrlReg, cfgReg, thrReg;
    logic [1:0] idx_r, idx_nxt;
    logic [3:0] retry_r, retry_nxt;
    logic [7:0] wait_r, wait_nxt;
    logic accPin_r, accPin_nxt;
    logic [NPINS-1:0] pu_r, pu_nxt, pd_r, pd_nxt;
    logic [31:0] res_r, res_nxt;
    logic [31:0] accRes_r, accRes_nxt;
    logic clearAcc, burstDone, seqDone;
    logic [7:0] meanValue, lowestValue, highestValue;
    logic [7:0] stepThr, shiftFactor;
    logic sidebandOnly, retryCond;
    logic [NPINS-1:0] manPu, manPd;
    logic [2:0] sampleCountExponent;
    logic [3:0] retryLimit, groundLevelThreshold;
    logic [5:0] noiseClampRange, generalShiftFactor;
    logic [4:0] sidebandShiftFactor;
    logic accessoryMode;

    // register file
    rms_apb_regs u_regs (
        .clk(clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .resultWord(res_r),
        .statusWord({accRes_r[15:0], 12'h000, retry_r[1:0], idx_r[1], busy}),
        .seqDone(seqDone),
        .ctrlReg(ctrlReg),
        .cfgReg(cfgReg),
        .thrReg(thrReg)
    );

    // sample accumulator on the single shared ADC [R1]
    rms_sample_acc #(.W(8)) u_acc (
        .clk(clk),
        .rst(rst),
        .clear(clearAcc),
        .adcValid(adcValid && st_r == RMS_SAMPLE),
        .adcData(adcData),
        .sampleCountExponent(sampleCountExponent),
        .meanValue(meanValue),
        .lowestValue(lowestValue),
        .highestValue(highestValue),
        .burstDone(burstDone)
    );

    // configuration, threshold and control fields
    assign sampleCountExponent = cfgReg[RMS_AVG_POS +: 3];
    assign retryLimit = cfgReg[RMS_RETRY_POS +: 4];
    assign groundLevelThreshold = cfgReg[RMS_GND_POS +: 4];
    assign noiseClampRange = cfgReg[RMS_NOISE_POS +: 6];
    assign sidebandShiftFactor = thrReg[RMS_SBCORR_POS +: 5];
    assign generalShiftFactor = thrReg[RMS_GNCORR_POS +: 6];
    assign accessoryMode = ctrlReg[RMS_ACC_BIT];
    assign manPu = ctrlReg[RMS_PU_POS +: NPINS];
    assign manPd = ctrlReg[RMS_PD_POS +: NPINS];

    // shift factor selection and step threshold
    always_comb begin
        sidebandOnly = accessoryMode
            || ((pu_r & ~RMS_SB_MASK) == '0 && pu_r != '0); // [R8]
        shiftFactor = sidebandOnly ? 8'(sidebandShiftFactor)
                                   : 8'(generalShiftFactor); // [R7]
        stepThr = RMS_STEP_BASE - shiftFactor; // [R6]
        retryCond = (highestValue == RMS_FULL) &&
            ((idx_r == RMS_I2UA && meanValue < RMS_FULL - 8'(noiseClampRange))
             || idx_r != RMS_I2UA); // [R12]
    end

    // sequencer next state
    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        retry_nxt = retry_r;
        wait_nxt = wait_r;
        accPin_nxt = accPin_r;
        pu_nxt = pu_r;
        pd_nxt = pd_r;
        res_nxt = res_r;
        accRes_nxt = accRes_r;
        clearAcc = 1'b0;
        seqDone = 1'b0;
        case (st_r)
            RMS_IDLE: begin
                if (ctrlReg[RMS_START_BIT]) begin
                    idx_nxt = RMS_I2UA; // start at lowest current [R5]
                    retry_nxt = '0;
                    wait_nxt = '0;
                    accPin_nxt = 1'b0;
                    if (accessoryMode) begin
                        pu_nxt = RMS_SB_MASK & ~(RMS_SB_MASK << 1); // one sideband [R3]
                        pd_nxt = '0;
                    end else begin
                        pu_nxt = manPu;
                        pd_nxt = manPd & ~manPu;
                    end
                    st_nxt = RMS_SETTLE;
                end
            end
            RMS_SETTLE: begin
                clearAcc = 1'b1;
                wait_nxt = wait_r + 8'd1;
                if (wait_r >= 8'(SETTLE - 1)) begin
                    wait_nxt = '0;
                    st_nxt = RMS_SAMPLE;
                end
            end
            RMS_SAMPLE: begin
                if (burstDone) st_nxt = RMS_JUDGE;
            end
            RMS_JUDGE: begin
                st_nxt = RMS_DONE;
                if (meanValue < stepThr && idx_r != RMS_I128UA) begin
                    idx_nxt = idx_r + 2'd1; // four times the current [R5] [R16]
                    st_nxt = RMS_SETTLE;
                end else if (retryCond && retry_r < retryLimit) begin
                    retry_nxt = retry_r + 4'd1; // retry measurement [R12]
                    idx_nxt = RMS_I2UA;
                    st_nxt = RMS_SETTLE;
                end else if (retryCond) begin
                    res_nxt = {2'b00, 2'(RMS_ABORT), 2'b00, RMS_I2UA, 24'h000000}; // [R13]
                end else if (idx_r == RMS_I2UA && meanValue == RMS_FULL) begin
                    res_nxt = {2'b00, 2'(RMS_OPEN), 2'b00, RMS_I2UA,
                               RMS_FULL, RMS_FULL, RMS_FULL}; // [R10]
                end else if (idx_r == RMS_I128UA && meanValue <= 8'(groundLevelThreshold)) begin
                    res_nxt = {2'b00, 2'(RMS_GROUND), 2'b00, RMS_I128UA,
                               RMS_ZERO, RMS_ZERO, RMS_ZERO}; // [R11]
                end else begin
                    res_nxt = {2'b00, 2'(RMS_FINITE), 2'b00, idx_r,
                               highestValue, lowestValue, meanValue}; // [R14] [R9]
                end
            end
            RMS_DONE: begin
                if (accessoryMode && !accPin_r) begin
                    accRes_nxt[15:0] = res_r[15:0];
                    accPin_nxt = 1'b1;
                    pu_nxt = RMS_SB_MASK & (RMS_SB_MASK << 1); // other sideband [R3]
                    idx_nxt = RMS_I2UA;
                    retry_nxt = '0;
                    st_nxt = RMS_SETTLE;
                end else begin
                    seqDone = 1'b1;
                    pu_nxt = '0;
                    pd_nxt = '0;
                    st_nxt = RMS_IDLE;
                end
            end
            default: st_nxt = RMS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= RMS_IDLE;
            idx_r <= RMS_I2UA;
            retry_r <= '0;
            wait_r <= '0;
            accPin_r <= 1'b0;
            pu_r <= '0;
            pd_r <= '0;
            res_r <= '0;
            accRes_r <= '0;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            retry_r <= retry_nxt;
            wait_r <= wait_nxt;
            accPin_r <= accPin_nxt;
            pu_r <= pu_nxt;
            pd_r <= pd_nxt;
            res_r <= res_nxt;
            accRes_r <= accRes_nxt;
        end
    end

    // switch banks and current source drive [R2] [R1]
    assign forcedPullup = pu_r;
    assign sensedPullup = pu_r;
    assign pinPulldown = pd_r;
    assign currentSelect = idx_r;
    assign currentEnable = (st_r == RMS_SETTLE) || (st_r == RMS_SAMPLE);
    assign adcStart = (st_r == RMS_SAMPLE);
    assign busy = (st_r != RMS_IDLE);

    a_start_current: assert property (@(posedge clk) disable iff (rst)
        (st_r == RMS_IDLE && st_nxt == RMS_SETTLE) |=> idx_r == RMS_I2UA) // [R5]
        else $error("measurement did not start at lowest current");
    a_step_limit: assert property (@(posedge clk) disable iff (rst)
        (st_r == RMS_JUDGE && idx_r == RMS_I128UA) |=> idx_r == RMS_I128UA
        || st_r == RMS_SETTLE) // [R5]
        else $error("current stepped beyond the top value");
    a_acc_sideband: assert property (@(posedge clk) disable iff (rst)
        (busy && accessoryMode) |-> ((pu_r & ~RMS_SB_MASK) == '0
        && pu_r != RMS_SB_MASK)) // [R3]
        else $error("accessory pullup outside a single sideband pin");
    a_open_report: assert property (@(posedge clk) disable iff (rst)
        (st_r == RMS_DONE && res_r[29:28] == 2'(RMS_OPEN)) |->
        res_r[23:0] == 24'hffffff && res_r[25:24] == RMS_I2UA) // [R10]
        else $error("open result fields wrong");
    a_ground_report: assert property (@(posedge clk) disable iff (rst)
        (st_r == RMS_DONE && res_r[29:28] == 2'(RMS_GROUND)) |->
        res_r[23:0] == 24'h000000 && res_r[25:24] == RMS_I128UA) // [R11]
        else $error("ground result fields wrong");
    a_abort_report: assert property (@(posedge clk) disable iff (rst)
        (st_r == RMS_JUDGE && retryCond && retry_r >= retryLimit
         && !(meanValue < stepThr && idx_r != RMS_I128UA)) |=>
        res_r[29:28] == 2'(RMS_ABORT) && res_r[25:0] == 26'h0) // [R13]
        else $error("abort not reported after retries");
    a_retry_count: assert property (@(posedge clk) disable iff (rst)
        retry_r <= retryLimit || !busy) // [R12]
        else $error("retry count exceeded limit");
    a_shift_select: assert property (@(posedge clk) disable iff (rst)
        accessoryMode |-> shiftFactor == 8'(sidebandShiftFactor)) // [R7]
        else $error("accessory mode used general shift factor");
    a_finite_report: assert property (@(posedge clk) disable iff (rst)
        (st_r == RMS_DONE && res_r[29:28] == 2'(RMS_FINITE)) |->
        res_r[25:24] == $past(idx_r, 2)) // [R9]
        else $error("finite result index mismatch");
endmodule : rms_sequencer

// File: rms_pin_model.sv
// Purpose: behavioural pin network and adc answering the sequencer
// Assumes: level tables per current index, two alternating sample values
// Notes: data line shows a moving pattern whenever no sample is presented
`timescale 1ns/1ps
module rms_pin_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic adcStart,
    input wire logic [1:0] currentSelect,
    input wire logic currentEnable,
    input wire logic [6:0] forcedPullup,
    input wire logic [6:0] sensedPullup,
    input wire logic [31:0] levelA,
    input wire logic [31:0] levelB,
    input wire logic [1:0] gap,
    output logic adcValid,
    output logic [7:0] adcData
);
    logic [1:0] waitCnt;
    logic phase;
    logic [7:0] pick;
    // one 8-bit reading per current index, four currents
    always_comb begin
        pick = phase ? levelB[8*currentSelect +: 8] : levelA[8*currentSelect +: 8];
    end
    // sample pacing, burst always opens on the first value
    always @(posedge clk) begin
        adcValid <= 1'b0;
        adcData <= ~adcData;  // released line, inverse of last
        if (rst) begin
            adcData <= 8'h00;
        end
        if (rst || !adcStart) begin
            waitCnt <= gap;
            phase <= 1'b0;
        end else if (waitCnt != 2'd0) begin
            waitCnt <= waitCnt - 2'd1;
        end else begin
            waitCnt <= gap;
            phase <= ~phase;
            adcValid <= 1'b1;
            // sensed only through a pin tied to both nodes
            adcData <= (currentEnable && |(forcedPullup & sensedPullup)) ? pick : adcData + 8'h5b;
        end
    end
endmodule : rms_pin_model

// File: resistive_measurement_sequencer_tb.sv
// Purpose: self-checking bench for the resistive measurement sequencer
// Assumes: apb master at the rising edge, pin model on the analog side
// Notes: expected results come from expRes, stimulus from an lfsr seeded 57
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module resistive_measurement_sequencer_tb
    import rms_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, adcStart, adcValid, currentEnable, busy;
    logic [7:0] adcData;
    logic [1:0] currentSelect;
    logic [6:0] forcedPullup, sensedPullup, pinPulldown;
    logic [31:0] levelA = 32'h0;
    logic [31:0] levelB = 32'h0;
    logic [1:0] gap = 2'd0;
    logic accMode = 1'b0;
    logic [6:0] puSet = 7'h00;
    logic [6:0] pdSet = 7'h00;
    logic [6:0] seenSb = 7'h00;
    logic [15:0] seed = 16'h0039;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    rms_sequencer #(.NPINS(RMS_NPINS), .SETTLE(RMS_SETTLE_CYC)) u_dut (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .adcStart(adcStart),
        .adcValid(adcValid), .adcData(adcData), .currentSelect(currentSelect),
        .currentEnable(currentEnable), .forcedPullup(forcedPullup),
        .sensedPullup(sensedPullup), .pinPulldown(pinPulldown), .busy(busy));
    rms_pin_model u_pins (.clk(clk), .rst(rst), .adcStart(adcStart),
        .currentSelect(currentSelect), .currentEnable(currentEnable),
        .forcedPullup(forcedPullup), .sensedPullup(sensedPullup), .levelA(levelA),
        .levelB(levelB), .gap(gap), .adcValid(adcValid), .adcData(adcData));
    // clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end
    // verdict and end of run
    task automatic conclude;
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            conclude();
        end
    end
    // switch pattern while the current source is live
    always @(negedge clk) begin
        if (busy === 1'b1 && currentEnable === 1'b1) begin
            seenSb = seenSb | forcedPullup;
            `CHK(sensedPullup, forcedPullup);
            if (accMode) begin
                `CHK(forcedPullup == 7'h04 || forcedPullup == 7'h08, 1'b1);
            end else begin
                `CHK(forcedPullup, puSet);
                `CHK(pinPulldown, pdSet & ~puSet);
            end
        end
    end
    // lfsr step
    task automatic step;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    endtask : step
    // expected result word of one measurement
    function automatic logic [31:0] expRes(input logic [31:0] la, input logic [31:0] lb,
        input logic [2:0] e, input logic [5:0] s, input logic [3:0] g);
        logic [7:0] m, hi, lo, a, b, thr;
        int i;
        thr = RMS_STEP_BASE - {2'b00, s};
        for (i = 0; i < 4; i++) begin
            a = la[8*i +: 8];
            b = (e == 3'd0) ? a : lb[8*i +: 8];
            m = 8'((9'(a) + 9'(b)) >> 1);
            hi = (a > b) ? a : b;
            lo = (a > b) ? b : a;
            if (m >= thr || i == 3) break;
        end
        if (i == 3 && m <= {4'h0, g}) return 32'h1300_0000;
        if (hi == RMS_FULL && (i > 0 || m < RMS_FULL - {4'h0, g})) return 32'h2000_0000;
        if (m == RMS_FULL) return 32'h00ff_ffff;
        return {4'h3, 2'b00, 2'(i), hi, lo, m};
    endfunction : expRes
    // one apb transfer, answer taken in the cycle pready is high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // read and compare data and error flag
    task automatic chkRd(input logic [7:0] addr, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, addr, 32'h0, rd, er);
        `CHK(rd, exp);
        `CHK(er, experr);
    endtask : chkRd
    // configure, start, wait and check one measurement
    task automatic run(input logic acc, input logic [6:0] pu, input logic [6:0] pd,
        input logic [2:0] e, input logic [3:0] r, input logic [3:0] g,
        input logic [4:0] sb, input logic [5:0] gen);
        logic [31:0] rd, ex;
        logic er;
        logic [5:0] s;
        int n;
        s = (acc || (pu & ~RMS_SB_MASK) == 7'h00) ? {1'b0, sb} : gen;
        ex = expRes(levelA, levelB, e, s, g);
        accMode = acc;
        puSet = pu;
        pdSet = pd;
        seenSb = 7'h00;
        apb(1'b1, RMS_THR_OFS, {18'h0, gen, 3'h0, sb}, rd, er);
        apb(1'b1, RMS_CFG_OFS, {12'h0, g, 4'h0, g, r, 1'b0, e}, rd, er);
        apb(1'b1, RMS_CTRL_OFS, {9'h0, pd, 1'b0, pu, 6'h0, acc, 1'b1}, rd, er);
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        while (busy !== 1'b0) @(negedge clk);
        chkRd(RMS_RES_OFS, ex, 1'b0);
        apb(1'b0, RMS_CTRL_OFS, 32'h0, rd, er);
        `CHK(rd[0], 1'b0);
        if (acc) begin
            apb(1'b0, RMS_STAT_OFS, 32'h0, rd, er);
            `CHK(rd[31:16], ex[15:0]);
            `CHK(seenSb, 7'h0c);
        end
    endtask : run
    // main sequence
    initial begin
        logic [31:0] rd;
        logic er;
        logic [7:0] base, a;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chkRd(RMS_CFG_OFS, RMS_CFG_RST, 1'b0);
        chkRd(RMS_THR_OFS, RMS_THR_RST, 1'b0);
        chkRd(RMS_CTRL_OFS, RMS_CTRL_RST, 1'b0);
        apb(1'b1, 8'h18, 32'hffff_ffff, rd, er);
        chkRd(8'h18, 32'h0, 1'b1);
        chkRd(RMS_CFG_OFS, RMS_CFG_RST, 1'b0);
        levelA = 32'hffff_ffff;
        levelB = 32'hffff_ffff;
        run(1'b0, 7'h01, 7'h7e, 3'd2, 4'd2, 4'd4, 5'h00, 6'h00);
        levelA = 32'h0202_0202;
        levelB = 32'h0303_0303;
        run(1'b0, 7'h02, 7'h7d, 3'd3, 4'd2, 4'd4, 5'h00, 6'h00);
        levelA = 32'h2020_1008;
        levelB = 32'h2424_1008;
        run(1'b0, 7'h10, 7'h6f, 3'd1, 4'd2, 4'd4, 5'h00, 6'h00);
        levelA = 32'h8080_8010;
        levelB = 32'hffff_ff10;
        run(1'b0, 7'h01, 7'h00, 3'd1, 4'd2, 4'd4, 5'h00, 6'h00);
        levelA = 32'h0000_0080;
        levelB = 32'h0000_00ff;
        run(1'b0, 7'h01, 7'h00, 3'd1, 4'd1, 4'd4, 5'h00, 6'h00);
        apb(1'b1, RMS_RES_OFS, 32'h0, rd, er);
        chkRd(RMS_RES_OFS, 32'h2000_0000, 1'b0);
        levelA = 32'h0000_0035;
        levelB = 32'h0000_0035;
        run(1'b0, 7'h0c, 7'h73, 3'd0, 4'd2, 4'd4, 5'h10, 6'h00);
        run(1'b0, 7'h0d, 7'h72, 3'd0, 4'd2, 4'd4, 5'h10, 6'h00);
        run(1'b1, 7'h7f, 7'h00, 3'd0, 4'd2, 4'd4, 5'h10, 6'h00);
        for (int k = 0; k < 24; k++) begin
            step();
            base = seed[7:0] >> seed[10:8];
            for (int i = 0; i < 4; i++) begin
                step();
                a = (base > (8'hff >> (2 * i))) ? 8'hff : 8'(base << (2 * i));
                levelA[8*i +: 8] = a;
                levelB[8*i +: 8] = (a > 8'hf8) ? 8'hff : a + {5'h0, seed[2:0]};
            end
            step();
            gap = seed[1:0];
            step();
            run(k % 6 == 5, seed[0] ? (RMS_SB_MASK & seed[7:1]) | 7'h04 : seed[7:1] | 7'h01,
                seed[14:8], 3'(seed[15:13] % 5), {2'b00, seed[3:2]} + 4'd1, seed[11:8],
                seed[12:8], {1'b0, seed[7:3]});
        end
        conclude();
    end
endmodule : resistive_measurement_sequencer_tb
